// *** rtl/spdb_map.vh ***
`ifndef SPDB_MAP_VH
`define SPDB_MAP_VH

// ----------------------------------------------------------------------
// Build defaults
// ----------------------------------------------------------------------
`define SPDB_DW_DEF          18
`define SPDB_AW_DEF          20
`define SPDB_NBW_DEF         2

// ----------------------------------------------------------------------
// Read latency in output clock half-edges after the address edge
// ----------------------------------------------------------------------
`define SPDB_LAT_DLL_EDGES   2'd3
`define SPDB_LAT_BYP_EDGES   2'd2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SPDB_ECHO_RST        1'b0
`define SPDB_ECHO_N_RST      1'b1

`endif

// *** rtl/spdb_sync.v ***
// ----------------------------------------------------------------------
// Two-stage synchroniser for a bundle of pin inputs
// ----------------------------------------------------------------------
module spdb_sync #(
   parameter W = 8
) (
   // Clock and reset
   input  wire         sys_clk,
   input  wire         rst,
   // Pins and synchronised copy
   input  wire [W-1:0] pin_in,
   output reg  [W-1:0] pin_sync
);

   reg [W-1:0] meta_reg;

   always @(posedge sys_clk) begin
      if (rst) begin
         meta_reg <= {W{1'b0}};
         pin_sync <= {W{1'b0}};
      end else begin
         meta_reg <= pin_in;
         pin_sync <= meta_reg;
      end
   end

endmodule

// *** rtl/spdb_array.v ***
// ----------------------------------------------------------------------
// Storage array: one entry holds both burst words, lane write enables
// ----------------------------------------------------------------------
module spdb_array #(
   parameter AW = 20,
   parameter EW = 36,
   parameter NL = 4
) (
   // Clock
   input  wire          sys_clk,
   // Write side
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [EW-1:0] wdata,
   input  wire [NL-1:0] wen,
   // Read side
   input  wire          re,
   input  wire [AW-1:0] raddr,
   output reg  [EW-1:0] rdata
);

   localparam LW = EW / NL;

   reg [EW-1:0] mem [0:(1<<AW)-1];
   integer      l;

   always @(posedge sys_clk) begin
      if (we) begin
         for (l = 0; l < NL; l = l + 1) begin
            if (wen[l]) begin
               mem[waddr][l*LW +: LW] <= wdata[l*LW +: LW];
            end
         end
      end
      if (re) begin
         rdata <= mem[raddr];
      end
   end

endmodule

// *** rtl/spdb_sram_core.v ***
`include "spdb_map.vh"

module spdb_sram_core #(
   parameter DW  = `SPDB_DW_DEF,
   parameter AW  = `SPDB_AW_DEF,
   parameter NBW = `SPDB_NBW_DEF
) (
   // Clock and reset
   input  wire           sys_clk,
   input  wire           rst,
   // Input timing clock pair
   input  wire           k_clk,
   input  wire           k_clk_n,
   // Output clock pair and mode straps
   input  wire           c_clk,
   input  wire           c_clk_n,
   input  wire           single_clock_mode,
   input  wire           loop_bypass_n,
   // Shared address and port selects
   input  wire [AW-1:0]  addr,
   input  wire           rd_sel_n,
   input  wire           wr_sel_n,
   // Write port
   input  wire [DW-1:0]  wr_data,
   input  wire [NBW-1:0] byte_wr_n,
   // Read port
   output reg  [DW-1:0]  rd_data,
   output reg            echo_strobe,
   output reg            echo_strobe_n
);

   localparam SW = 8 + AW + DW + NBW;
   localparam LW = DW / NBW;

   localparam WS_IDLE = 2'b00;
   localparam WS_ADDR = 2'b01;
   localparam WS_HALF = 2'b10;

   // ----------------------------------------------------------------------
   // Pin synchronisation and edge detection
   // ----------------------------------------------------------------------
   wire [SW-1:0]  pin_sync;
   wire           s_k;
   wire           s_k_n;
   wire           s_c;
   wire           s_c_n;
   wire           s_single;
   wire           s_bypass_n;
   wire           s_rsel_n;
   wire           s_wsel_n;
   wire [AW-1:0]  s_addr;
   wire [DW-1:0]  s_wdata;
   wire [NBW-1:0] s_bw_n;
   reg  [3:0]     clk_prev_reg;

   spdb_sync #(
      .W (SW)
   ) u_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .pin_in   ({k_clk, k_clk_n, c_clk, c_clk_n, single_clock_mode, loop_bypass_n,
                  rd_sel_n, wr_sel_n, addr, wr_data, byte_wr_n}),
      .pin_sync (pin_sync)
   );

   assign {s_k, s_k_n, s_c, s_c_n, s_single, s_bypass_n,
           s_rsel_n, s_wsel_n, s_addr, s_wdata, s_bw_n} = pin_sync;

   // Previous samples of the four clock pins, for rising-edge detection.
   always @(posedge sys_clk) begin
      if (rst) begin
         clk_prev_reg <= 4'h0;
      end else begin
         clk_prev_reg <= {s_k, s_k_n, s_c, s_c_n};
      end
   end

   wire k_rise  = s_k   & ~clk_prev_reg[3];
   wire kn_rise = s_k_n & ~clk_prev_reg[2];
   wire c_rise  = s_c   & ~clk_prev_reg[1];
   wire cn_rise = s_c_n & ~clk_prev_reg[0];

   wire o_true  = s_single ? k_rise  : c_rise;
   wire o_comp  = s_single ? kn_rise : cn_rise;
   wire o_edge  = o_true | o_comp;

   // ----------------------------------------------------------------------
   // Lane merge helper
   // ----------------------------------------------------------------------
   function [2*DW-1:0] lane_merge;
      input [2*DW-1:0]  old_val;
      input [2*DW-1:0]  new_val;
      input [2*NBW-1:0] en;
      integer           i;
      begin
         for (i = 0; i < 2*DW; i = i + 1) begin
            lane_merge[i] = en[i/LW] ? new_val[i] : old_val[i];
         end
      end
   endfunction

   // ----------------------------------------------------------------------
   // Write port
   // ----------------------------------------------------------------------
   reg [1:0]       ws_reg;
   reg [AW-1:0]    pend_addr_reg;
   reg [DW-1:0]    pend_data_reg;
   reg [NBW-1:0]   pend_be_reg;
   reg             mem_we_reg;
   reg [AW-1:0]    mem_waddr_reg;
   reg [2*DW-1:0]  mem_wdata_reg;
   reg [2*NBW-1:0] mem_wen_reg;

   wire commit = kn_rise & (ws_reg == WS_HALF);

   always @(posedge sys_clk) begin
      if (rst) begin
         ws_reg        <= WS_IDLE;
         pend_addr_reg <= {AW{1'b0}};
         pend_data_reg <= {DW{1'b0}};
         pend_be_reg   <= {NBW{1'b0}};
         mem_we_reg    <= 1'b0;
         mem_waddr_reg <= {AW{1'b0}};
         mem_wdata_reg <= {2*DW{1'b0}};
         mem_wen_reg   <= {2*NBW{1'b0}};
      end else begin
         mem_we_reg <= 1'b0;
         if (kn_rise) begin
            if (commit) begin
               mem_we_reg    <= 1'b1;
               mem_waddr_reg <= pend_addr_reg;
               mem_wdata_reg <= {s_wdata, pend_data_reg};
               mem_wen_reg   <= {~s_bw_n, pend_be_reg};
            end
            if (!s_wsel_n) begin
               pend_addr_reg <= s_addr;
               pend_be_reg   <= {NBW{1'b0}};
               ws_reg        <= WS_ADDR;
            end else begin
               pend_be_reg   <= {NBW{1'b0}};
               ws_reg        <= WS_IDLE;
            end
         end else if (k_rise && ws_reg == WS_ADDR) begin
            pend_data_reg <= s_wdata;
            pend_be_reg   <= ~s_bw_n;
            ws_reg        <= WS_HALF;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   wire [2*DW-1:0] mem_rdata;
   reg             mem_re_reg;
   reg [AW-1:0]    mem_raddr_reg;

   spdb_array #(
      .AW (AW),
      .EW (2*DW),
      .NL (2*NBW)
   ) u_array (
      .sys_clk (sys_clk),
      .we      (mem_we_reg),
      .waddr   (mem_waddr_reg),
      .wdata   (mem_wdata_reg),
      .wen     (mem_wen_reg),
      .re      (mem_re_reg),
      .raddr   (mem_raddr_reg),
      .rdata   (mem_rdata)
   );

   // ----------------------------------------------------------------------
   // Read port: two in-flight slots
   // ----------------------------------------------------------------------
   // own port selects
   wire rd_take = k_rise & ~s_rsel_n;

   reg [1:0]      slot_valid;
   reg [1:0]      slot_fwd;
   reg [1:0]      slot_cnt  [0:1];
   reg [AW-1:0]   slot_addr [0:1];
   reg [2*DW-1:0] slot_data [0:1];
   reg            slot_wp_reg;
   reg            load_reg;
   reg            load_idx_reg;
   reg            load_d_reg;
   integer        s;

   always @(posedge sys_clk) begin
      if (rst) begin
         mem_re_reg    <= 1'b0;
         mem_raddr_reg <= {AW{1'b0}};
      end else begin
         mem_re_reg <= rd_take;
         if (rd_take) begin
            mem_raddr_reg <= s_addr;
         end
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         slot_valid    <= 2'b00;
         slot_fwd      <= 2'b00;
         slot_wp_reg   <= 1'b0;
         load_reg      <= 1'b0;
         load_d_reg    <= 1'b0;
         load_idx_reg  <= 1'b0;
         rd_data       <= {DW{1'b0}};
         echo_strobe   <= `SPDB_ECHO_RST;
         echo_strobe_n <= `SPDB_ECHO_N_RST;
         for (s = 0; s < 2; s = s + 1) begin
            slot_cnt[s]  <= 2'd0;
            slot_addr[s] <= {AW{1'b0}};
            slot_data[s] <= {2*DW{1'b0}};
         end
      end else begin
         if (o_true) begin
            echo_strobe   <= 1'b1;
            echo_strobe_n <= 1'b0;
         end else if (o_comp) begin
            echo_strobe   <= 1'b0;
            echo_strobe_n <= 1'b1;
         end
         for (s = 0; s < 2; s = s + 1) begin
            if (o_edge && slot_valid[s]) begin
               if (slot_cnt[s] == 2'd1) begin
                  rd_data     <= slot_data[s][DW-1:0];
                  slot_cnt[s] <= 2'd0;
               end else if (slot_cnt[s] == 2'd0) begin
                  rd_data       <= slot_data[s][2*DW-1:DW];
                  slot_valid[s] <= 1'b0;
               end else begin
                  slot_cnt[s] <= slot_cnt[s] - 2'd1;
               end
            end
            if (commit && slot_fwd[s] && slot_addr[s] == pend_addr_reg) begin
               slot_data[s] <= lane_merge(slot_data[s], {s_wdata, {DW{1'b0}}},
                                          {~s_bw_n, {NBW{1'b0}}});
            end
            if (kn_rise && !s_wsel_n) begin
               slot_fwd[s] <= 1'b0;
            end
         end
         // The array answers one cycle after its strobe, so the slot loads a cycle later.
         load_reg   <= rd_take;
         load_d_reg <= load_reg;
         if (load_d_reg) begin
            if (slot_fwd[load_idx_reg] && slot_addr[load_idx_reg] == pend_addr_reg) begin
               slot_data[load_idx_reg] <= lane_merge(mem_rdata, {{DW{1'b0}}, pend_data_reg},
                                                     {{NBW{1'b0}}, pend_be_reg});
            end else begin
               slot_data[load_idx_reg] <= mem_rdata;
            end
         end
         if (rd_take) begin
            slot_valid[slot_wp_reg] <= 1'b1;
            slot_addr[slot_wp_reg]  <= s_addr;
            slot_fwd[slot_wp_reg]   <= (ws_reg == WS_ADDR);
            slot_cnt[slot_wp_reg]   <= s_bypass_n ? `SPDB_LAT_DLL_EDGES
                                                  : `SPDB_LAT_BYP_EDGES;
            load_idx_reg            <= slot_wp_reg;
            slot_wp_reg             <= ~slot_wp_reg;
         end
      end
   end

endmodule

// *** testbench/spdb_sram_core_asserts.sv ***
module spdb_chk_asserts #(
   parameter DW = 18
) (
   // Clock, reset and pins seen by the checker
   input wire          sys_clk,
   input wire          rst,
   input wire          k_clk,
   input wire          c_clk,
   input wire          c_clk_n,
   input wire          single_clock_mode,
   input wire          rd_sel_n,
   input wire [DW-1:0] rd_data,
   input wire          echo_strobe,
   input wire          echo_strobe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Cycles since the last offered read, saturating.
   logic [5:0] age_reg;
   always @(posedge sys_clk) begin
      if (rst)
         age_reg <= 6'h3f;
      else if ($rose(k_clk) && !rd_sel_n)
         age_reg <= 6'h00;
      else if (age_reg != 6'h3f)
         age_reg <= age_reg + 6'h01;
   end

   a_echo_pair: assert property (echo_strobe_n == !echo_strobe)
      else $error("echo strobes not complementary");
   a_reset_vals: assert property (disable iff (1'h0)
      rst |=> rd_data == '0 && !echo_strobe)
      else $error("outputs not cleared by reset");
   a_echo_rise_c: assert property (
      $rose(echo_strobe) && !single_clock_mode |-> $past(c_clk, 2) && !$past(c_clk, 5))
      else $error("echo rise without output clock rise");
   a_echo_fall_cn: assert property (
      $fell(echo_strobe) && !single_clock_mode |-> $past(c_clk_n, 2) && !$past(c_clk_n, 5))
      else $error("echo fall without output clock complement rise");
   a_single_k: assert property (
      $rose(echo_strobe) && single_clock_mode |-> $past(k_clk, 2) && !$past(k_clk, 5))
      else $error("echo rise without input clock rise");
   a_idle_quiet: assert property (
      ($stable(k_clk) && $stable(c_clk) && $stable(c_clk_n))[*6] |=> $stable(echo_strobe))
      else $error("echo moved with clocks idle");
   a_read_cause: assert property ($changed(rd_data) |-> age_reg < 6'h1e)
      else $error("read data changed without a read");
   a_no_early: assert property (
      $rose(k_clk) && !rd_sel_n && age_reg > 6'h16 |=> $stable(rd_data)[*8])
      else $error("read data too early");
endmodule

bind spdb_sram_core spdb_chk_asserts #(.DW(DW)) i_spdb_chk_asserts (
   .sys_clk(sys_clk), .rst(rst), .k_clk(k_clk), .c_clk(c_clk), .c_clk_n(c_clk_n),
   .single_clock_mode(single_clock_mode), .rd_sel_n(rd_sel_n), .rd_data(rd_data),
   .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n));

// *** testbench/spdb_ctl_model.sv ***
module spdb_ctl_model #(
   parameter DW  = 18,
   parameter AW  = 6,
   parameter NBW = 2
) (
   // Bench side
   input  wire             sys_clk,
   input  wire             rst,
   input  wire             sc,
   input  wire             rd_req,
   input  wire [AW-1:0]    rd_a,
   input  wire             wr_req,
   input  wire [AW-1:0]    wr_a,
   input  wire [2*DW-1:0]  wr_w,
   input  wire [2*NBW-1:0] wr_bw,
   output logic [2:0]      ph,
   // Pins
   output logic            k_clk,
   output logic            k_clk_n,
   output wire             c_clk,
   output wire             c_clk_n,
   output logic [AW-1:0]   addr,
   output logic            rd_sel_n,
   output logic            wr_sel_n,
   output logic [DW-1:0]   wr_data,
   output logic [NBW-1:0]  byte_wr_n
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam PW = 2*DW + 2*NBW;
   logic [PW-1:0] p0, p1, sw;
   logic          p0v, p1v, srr, swr;
   logic [AW-1:0] sra, swa;
   logic [2:0]    sph;
   // Output clocks stop in single clock mode.
   assign c_clk   = sc ? 1'h0 : k_clk;
   assign c_clk_n = sc ? 1'h0 : k_clk_n;
   initial begin
      {k_clk, p0v, p1v} = 3'h0;
      {k_clk_n, rd_sel_n, wr_sel_n} = 3'h7;
      {addr, wr_data, byte_wr_n, ph} = '0;
   end
   // clock pair, own selects, address on its edge
   always @(posedge sys_clk) begin
      sph = ph;
      {srr, sra, swr, swa} = {rd_req, rd_a, wr_req, wr_a};
      sw = {wr_bw, wr_w};
      ph <= rst ? 3'h0 : ph + 3'h1;
      #1;
      if (!rst && sph == 3'h7) begin
         {k_clk, k_clk_n, wr_sel_n, rd_sel_n} = {3'h5, !srr};
         addr = srr ? sra : ~addr;
         // first word on the true clock rise
         {byte_wr_n, wr_data} = p0v ? {p0[2*DW+NBW-1:2*DW], p0[DW-1:0]}
                                    : ~{byte_wr_n, wr_data};
         {p1, p1v, p0v} = {p0, p0v, 1'h0};
      end else if (!rst && sph == 3'h3) begin
         {k_clk, k_clk_n, rd_sel_n, wr_sel_n} = {3'h3, !swr};
         addr = swr ? swa : ~addr;
         // second word on the complement rise
         {byte_wr_n, wr_data} = p1v ? {p1[PW-1:2*DW+NBW], p1[2*DW-1:DW]}
                                    : ~{byte_wr_n, wr_data};
         {p0, p0v, p1v} = {sw, swr, 1'h0};
      end
   end
endmodule

// *** testbench/tb_top.sv ***
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DW = 18;
   localparam int AW = 6;
   localparam [35:0] A0 = {18'h3cdef, 18'h12345};
   localparam [35:0] LN = {18'h001ef, 18'h12200};
   localparam [35:0] B0 = {18'h0a5a5, 18'h15a5a};
   localparam [35:0] X0 = {18'h2b3c4, 18'h05a69};
   logic          sys_clk = 1'h0;
   logic          rst = 1'h1;
   logic          sc = 1'h0;
   logic          byp_n = 1'h1;
   logic          rd_req = 1'h0;
   logic          wr_req = 1'h0;
   logic [AW-1:0] rd_a = '0;
   logic [AW-1:0] wr_a = '0;
   logic [35:0]   wr_w = '0;
   logic [3:0]    wr_bw = '0;
   logic [2:0]    ph;
   logic [AW-1:0] addr;
   logic [DW-1:0] wr_data, rd_data;
   logic [1:0]    byte_wr_n;
   logic          k_clk, k_clk_n, c_clk, c_clk_n, rd_sel_n, wr_sel_n, echo, echo_n;
   int            n_mismatch = 0;
   int            n_checks = 0;

   always #25 sys_clk = ~sys_clk;

   spdb_ctl_model #(.DW(DW), .AW(AW), .NBW(2)) i_spdb_ctl_model (.sys_clk(sys_clk),
      .rst(rst), .sc(sc), .rd_req(rd_req), .rd_a(rd_a), .wr_req(wr_req), .wr_a(wr_a),
      .wr_w(wr_w), .wr_bw(wr_bw), .ph(ph), .k_clk(k_clk), .k_clk_n(k_clk_n),
      .c_clk(c_clk), .c_clk_n(c_clk_n), .addr(addr), .rd_sel_n(rd_sel_n),
      .wr_sel_n(wr_sel_n), .wr_data(wr_data), .byte_wr_n(byte_wr_n));
   spdb_sram_core #(.DW(DW), .AW(AW), .NBW(2)) i_spdb_sram_core (.sys_clk(sys_clk),
      .rst(rst), .k_clk(k_clk), .k_clk_n(k_clk_n), .c_clk(c_clk), .c_clk_n(c_clk_n),
      .single_clock_mode(sc), .loop_bypass_n(byp_n), .addr(addr), .rd_sel_n(rd_sel_n),
      .wr_sel_n(wr_sel_n), .wr_data(wr_data), .byte_wr_n(byte_wr_n), .rd_data(rd_data),
      .echo_strobe(echo), .echo_strobe_n(echo_n));

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp, input string nm);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Presents one request set for a whole input clock period.
   task automatic cyc(input logic rr, input logic [AW-1:0] ra, input logic wr,
                      input logic [AW-1:0] wa, input logic [35:0] w, input logic [3:0] bw);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (ph !== 3'h7 && n < 20);
      if (n >= 20) begin
         n_mismatch++;
         test_done();
      end
      {rd_req, rd_a, wr_req, wr_a, wr_w, wr_bw} = {rr, ra, wr, wa, w, bw};
   endtask

   task automatic idle(input int n);
      repeat (n) cyc(1'h0, 6'h00, 1'h0, 6'h00, 36'h0, 4'h0);
   endtask

   // Called one idle period after a read; lat is sys_clk edges to the word0 sample.
   task automatic rchk(input int lat, input logic [35:0] exp);
      repeat (lat - 7) @(posedge sys_clk);
      #1;
      chk(rd_data, exp[17:0], "rd_data word0");
      repeat (4) @(posedge sys_clk);
      #1;
      chk(rd_data, exp[35:18], "rd_data word1");
   endtask

   task automatic s_reset;
      chk(rd_data, 18'h0, "rd_data reset");
      chk(DW'(echo), 18'h0, "echo_strobe reset");
      chk(DW'(echo_n), 18'h1, "echo_strobe_n reset");
   endtask

   task automatic s_write_read;
      cyc(1'h0, 6'h00, 1'h1, 6'h05, A0, 4'h0);
      idle(3);
      cyc(1'h1, 6'h05, 1'h0, 6'h00, 36'h0, 4'h0);
      idle(1);
      rchk(18, A0);
   endtask

   task automatic s_bypass;
      byp_n = 1'h0;
      cyc(1'h1, 6'h05, 1'h0, 6'h00, 36'h0, 4'h0);
      idle(1);
      rchk(14, A0);
      byp_n = 1'h1;
   endtask

   task automatic s_lanes;
      cyc(1'h0, 6'h00, 1'h1, 6'h05, 36'h0, 4'h6);
      idle(3);
      cyc(1'h1, 6'h05, 1'h0, 6'h00, 36'h0, 4'h0);
      idle(1);
      rchk(18, LN);
   endtask

   task automatic s_concurrent;
      cyc(1'h1, 6'h05, 1'h1, 6'h2a, B0, 4'h0);
      idle(1);
      rchk(18, LN);
      cyc(1'h1, 6'h2a, 1'h0, 6'h00, 36'h0, 4'h0);
      idle(1);
      rchk(18, B0);
   endtask

   task automatic s_forward;
      cyc(1'h0, 6'h00, 1'h1, 6'h2a, X0, 4'h0);
      cyc(1'h1, 6'h2a, 1'h0, 6'h00, 36'h0, 4'h0);
      idle(1);
      rchk(18, X0);
   endtask

   task automatic s_deselect;
      cyc(1'h0, 6'h05, 1'h0, 6'h00, 36'h0, 4'h0);
      idle(1);
      rchk(18, {X0[35:18], X0[35:18]});
   endtask

   task automatic s_single;
      sc = 1'h1;
      cyc(1'h1, 6'h05, 1'h0, 6'h00, 36'h0, 4'h0);
      idle(1);
      rchk(18, LN);
   endtask

   initial begin
      repeat (20) @(posedge sys_clk);
      #1;
      rst = 1'h0;
      s_reset();
      s_write_read();
      s_bypass();
      s_lanes();
      s_concurrent();
      s_forward();
      s_deselect();
      s_single();
      test_done();
   end
endmodule
